/* pkg/spcp_pkg.sv */
// Constants and types shared by the serial port and control pin logic.
package spcp_pkg;

  // ****************************************
  // Sizes
  // ****************************************

  // Number of clock outputs that the enable and format fields cover.
  localparam int unsigned NUM_OUT = 12;
  // Width of the format selection field of one clock output.
  localparam int unsigned FMT_W = 3;
  // Width of the status vector watched for changes.
  localparam int unsigned STAT_W = 4;
  // Width of one serial byte.
  localparam int unsigned BYTE_W = 8;
  // Number of pins that pass the two-flop synchroniser.
  localparam int unsigned PIN_W = 7;

  // ****************************************
  // Pin positions in the synchroniser vector
  // ****************************************

  localparam int unsigned PIN_DATA = 0;
  localparam int unsigned PIN_OUT_DIS = 1;
  localparam int unsigned PIN_DEV_RST = 2;
  localparam int unsigned PIN_ADDR0 = 3;
  localparam int unsigned PIN_ADDR1 = 4;
  localparam int unsigned PIN_THREE_W = 5;
  localparam int unsigned PIN_I2C_SEL = 6;

  // ****************************************
  // Counts and values after reset
  // ****************************************

  // Cycles the mode strap must settle after reset before it is latched.
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
  // Index of the last bit of a serial byte.
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Value after reset of all pin synchroniser flops.
  localparam logic [PIN_W-1:0] PIN_RST = 7'h00;
  // Value after reset of byte registers.
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  // Value after reset of the status history.
  localparam logic [STAT_W-1:0] STAT_RST = 4'h0;
  // Value after reset of the format fields.
  localparam logic [NUM_OUT*FMT_W-1:0] FMT_RST = 36'h0;
  // Clock output enables, all off and all on.
  localparam logic [NUM_OUT-1:0] OUT_OFF = 12'h000;
  localparam logic [NUM_OUT-1:0] OUT_ALL = 12'hFFF;

  // ****************************************
  // Serial interface mode
  // ****************************************

  // Waiting for the strap to settle, then I2C or SPI until the next reset.
  typedef enum logic [2:0] {
    SPCP_WAIT = 3'b001,
    SPCP_I2C = 3'b010,
    SPCP_SPI = 3'b100
  } spcp_mode_t;

endpackage

/* rtl/spcp_top.sv */
// Serial port pin multiplexer and control/status pin logic of the clock generator.
//
// Notes on behaviour
// - Strap high selects I2C, low selects SPI.
// - Data pin: SDA, SDIO three-wire, input four-wire.
// - I2C drives low or releases; SPI drives both.
// - Pin is address strap in I2C, output four-wire.
// - Host serial clock clocks interface in both modes.
// - Pin is address strap; SPI low selects device.
// - Interrupt output low after any status change.
// - Reset pin low restores all defaults except the serial link and the received byte, which still updates when a byte completes in reset.
// - Disable pin high stops all clock outputs.
// - Output formats come from register settings.
// - Lock indicator high when locked, low otherwise.
`timescale 1ns/1ps

module spcp_top (
  input wire logic sys_clk, // System clock, 200 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic serial_clk, // Serial clock from the host, link domain.
  input wire logic i2c_sel_pin, // Interface select strap.
  input wire logic spi_three_wire, // High selects three-wire SPI.
  input wire logic data_pin_i, // Shared data pin level.
  output logic data_pin_o, // Shared data pin drive value.
  output logic data_pin_oe, // Shared data pin drive enable.
  input wire logic addr1_or_dout_pin_i, // Address strap / data out pin level.
  output logic addr1_or_dout_pin_o, // Data out drive value.
  output logic addr1_or_dout_pin_oe, // Data out drive enable.
  input wire logic addr0_or_select_pin, // Address strap / select pin.
  input wire logic device_reset_n, // Device reset pin, active low.
  input wire logic output_disable_pin, // High disables all clock outputs.
  input wire logic core_drive_low, // Protocol core pulls the I2C line low.
  input wire logic core_dout, // Protocol core SPI data bit.
  input wire logic core_dout_en, // Protocol core wants to drive SPI data.
  input wire logic [spcp_pkg::STAT_W-1:0] status_vec, // Device status levels.
  input wire logic status_clear, // Clears the status change flag.
  input wire logic pll_locked, // PLL lock level.
  input wire logic [spcp_pkg::NUM_OUT*spcp_pkg::FMT_W-1:0] out_fmt_cfg, // Format settings.
  output logic mode_is_i2c, // Latched mode is I2C.
  output logic mode_is_spi, // Latched mode is SPI.
  output logic spi_selected, // SPI select pin is active.
  output logic [1:0] slave_addr_lsbs, // Strapped low address bits.
  output logic data_line_sync, // Synchronised data pin level.
  output logic [spcp_pkg::BYTE_W-1:0] rx_byte, // Last byte shifted in.
  output logic rx_byte_valid, // One-cycle pulse with a new byte.
  output logic status_change_irq_n, // Status change interrupt, active low.
  output logic lock_lost_n, // Lock indicator, low when out of lock.
  output logic [spcp_pkg::NUM_OUT-1:0] clk_out_en, // Clock output enables.
  output logic [spcp_pkg::NUM_OUT*spcp_pkg::FMT_W-1:0] clk_out_fmt, // Output formats.
  output logic core_rst_n // Reset for the rest of the device, active low.
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [spcp_pkg::PIN_W-1:0] pin_raw; // Asynchronous pin levels.
  logic [spcp_pkg::PIN_W-1:0] pin_s1_q; // First stage, read only by the second.
  logic [spcp_pkg::PIN_W-1:0] pin_s2_q; // Second stage, safe to use.

  assign pin_raw = {i2c_sel_pin, spi_three_wire, addr1_or_dout_pin_i, addr0_or_select_pin,
                    device_reset_n, output_disable_pin, data_pin_i};

  // Two flops per pin; the reset pin reads as asserted right after power-up.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_q <= spcp_pkg::PIN_RST;
      pin_s2_q <= spcp_pkg::PIN_RST;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  wire i2c_sel_s = pin_s2_q[spcp_pkg::PIN_I2C_SEL]; // Synchronised strap.
  wire three_w_s = pin_s2_q[spcp_pkg::PIN_THREE_W]; // Synchronised wiring select.
  wire addr1_s = pin_s2_q[spcp_pkg::PIN_ADDR1]; // Synchronised address strap 1.
  wire addr0_s = pin_s2_q[spcp_pkg::PIN_ADDR0]; // Synchronised address/select.
  wire out_dis_s = pin_s2_q[spcp_pkg::PIN_OUT_DIS]; // Synchronised output disable.
  wire soft_rst = ~pin_s2_q[spcp_pkg::PIN_DEV_RST]; // Device reset pin held low.

  // ****************************************
  // Mode selection
  // ****************************************
  spcp_pkg::spcp_mode_t mode_q; // Latched interface mode.
  spcp_pkg::spcp_mode_t mode_d; // Next interface mode.
  logic [1:0] settle_q; // Strap settle counter.
  logic [1:0] settle_d; // Next settle count.
  // The strap is latched once after reset, so a host toggling it mid-use
  // cannot switch pin roles under a running transfer.
  always_comb begin
    mode_d = mode_q;
    settle_d = settle_q;
    case (mode_q)
      spcp_pkg::SPCP_WAIT: begin
        // Count until the strap has settled, then pick the mode.
        if (settle_q == spcp_pkg::SETTLE_CYCLES) begin
          mode_d = i2c_sel_s ? spcp_pkg::SPCP_I2C : spcp_pkg::SPCP_SPI;
        end else begin
          settle_d = settle_q + 2'h1;
        end
      end
      spcp_pkg::SPCP_I2C: mode_d = spcp_pkg::SPCP_I2C; // Held until reset.
      spcp_pkg::SPCP_SPI: mode_d = spcp_pkg::SPCP_SPI; // Held until reset.
      default: mode_d = spcp_pkg::SPCP_WAIT; // Illegal code recovers.
    endcase
  end

  // The device reset pin restarts the strap sequence as well.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= spcp_pkg::SPCP_WAIT;
      settle_q <= 2'h0;
    end else if (soft_rst) begin
      mode_q <= spcp_pkg::SPCP_WAIT;
      settle_q <= 2'h0;
    end else begin
      mode_q <= mode_d;
      settle_q <= settle_d;
    end
  end

  wire in_i2c = (mode_q == spcp_pkg::SPCP_I2C); // I2C mode active.
  wire in_spi = (mode_q == spcp_pkg::SPCP_SPI); // SPI mode active.
  wire sel_s = in_spi & ~addr0_s; // Host selects the device.

  // ****************************************
  // Pin drive decoding
  // ****************************************
  // Open drain in I2C: value is always low, only the enable moves.
  // Three-wire SPI drives the data pin both ways; four-wire leaves it input.
  wire dat_o_d = in_i2c ? 1'b0 : core_dout;
  wire dat_oe_d = ~soft_rst & (in_i2c ? core_drive_low :
                               (in_spi & three_w_s & sel_s & core_dout_en));
  // The second pin drives only in four-wire SPI; in I2C it is a strap input.
  wire a1_o_d = core_dout;
  wire a1_oe_d = ~soft_rst & in_spi & ~three_w_s & sel_s & core_dout_en;
  logic dat_o_q; // Registered data pin value.
  logic dat_oe_q; // Registered data pin enable.
  logic a1_o_q; // Registered data out value.
  logic a1_oe_q; // Registered data out enable.
  logic [1:0] addr_q; // Strapped address bits.

  // Pin drivers come from flops so no decode glitch reaches the board.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dat_o_q <= 1'b0;
      dat_oe_q <= 1'b0;
      a1_o_q <= 1'b0;
      a1_oe_q <= 1'b0;
      addr_q <= 2'h0;
    end else begin
      dat_o_q <= dat_o_d;
      dat_oe_q <= dat_oe_d;
      a1_o_q <= a1_o_d;
      a1_oe_q <= a1_oe_d;
      // Address straps are only meaningful in I2C mode.
      addr_q <= (in_i2c & ~soft_rst) ? {addr1_s, addr0_s} : 2'h0;
    end
  end

  // ****************************************
  // Link domain, clocked by the host clock
  // ****************************************
  // A deselect ends an SPI frame at once, even with the serial clock stopped.
  wire link_rst_n = arst_n & ~(in_spi & addr0_or_select_pin);
  logic [spcp_pkg::BYTE_W-1:0] shift_q; // Incoming bits.
  logic [2:0] bit_cnt_q; // Bit position in the byte.
  logic [spcp_pkg::BYTE_W-1:0] hold_q; // Completed byte for the crossing.
  logic byte_tgl_q; // Toggles once per completed byte.
  wire [spcp_pkg::BYTE_W-1:0] shift_d = {shift_q[spcp_pkg::BYTE_W-2:0], data_pin_i};

  // Only the bit count sees the deselect; a partial byte is simply never handed over.
  always_ff @(posedge serial_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_q <= 3'h0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  // The toggle keeps its level over a deselect, or the system side would see a false
  // byte. The host launches data against its own clock, so no synchroniser.
  always_ff @(posedge serial_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_q <= spcp_pkg::BYTE_RST;
      hold_q <= spcp_pkg::BYTE_RST;
      byte_tgl_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      if (bit_cnt_q == spcp_pkg::BIT_LAST) begin
        hold_q <= shift_d;
        byte_tgl_q <= ~byte_tgl_q;
      end
    end
  end

  // ****************************************
  // Byte crossing into the system domain
  // ****************************************
  logic tgl_s1_q; // First stage, read only by the second.
  logic tgl_s2_q; // Second stage.
  logic tgl_s3_q; // History for edge detection.
  logic [spcp_pkg::BYTE_W-1:0] rx_q; // Captured byte.
  logic rx_vld_q; // New byte pulse.
  wire tgl_edge = tgl_s2_q ^ tgl_s3_q;
  // The held byte stays stable for eight serial clocks, far longer than the
  // three system cycles the toggle takes, so it is safe to copy on the edge.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      rx_q <= spcp_pkg::BYTE_RST;
      rx_vld_q <= 1'b0;
    end else begin
      tgl_s1_q <= byte_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      rx_vld_q <= tgl_edge & ~soft_rst & (in_i2c | in_spi);
      if (tgl_edge) begin
        rx_q <= hold_q;
      end
    end
  end

  // ****************************************
  // Status change interrupt
  // ****************************************
  logic [spcp_pkg::STAT_W-1:0] stat_prev_q; // Status seen last cycle.
  logic primed_q; // History holds a real sample.
  logic irq_q; // Sticky change flag.
  wire stat_change = primed_q & (|(status_vec ^ stat_prev_q));
  // A change in the clearing cycle keeps the flag set.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_prev_q <= spcp_pkg::STAT_RST;
      primed_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (soft_rst) begin
      stat_prev_q <= spcp_pkg::STAT_RST;
      primed_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      stat_prev_q <= status_vec;
      primed_q <= 1'b1;
      irq_q <= stat_change | (irq_q & ~status_clear);
    end
  end

  // ****************************************
  // Clock output control and lock indicator
  // ****************************************
  logic [spcp_pkg::NUM_OUT-1:0] out_en_q; // Clock output enables.
  logic [spcp_pkg::NUM_OUT*spcp_pkg::FMT_W-1:0] fmt_q; // Output formats.
  logic lock_q; // Lock indicator.
  wire run_ok = ~soft_rst & ~out_dis_s & (in_i2c | in_spi);
  // Outputs stay off until the mode is latched; that is part of reset.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_en_q <= spcp_pkg::OUT_OFF;
      fmt_q <= spcp_pkg::FMT_RST;
      lock_q <= 1'b0;
    end else begin
      out_en_q <= run_ok ? spcp_pkg::OUT_ALL : spcp_pkg::OUT_OFF;
      fmt_q <= soft_rst ? spcp_pkg::FMT_RST : out_fmt_cfg;
      lock_q <= ~soft_rst & pll_locked;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign data_pin_o = dat_o_q;
  assign data_pin_oe = dat_oe_q;
  assign addr1_or_dout_pin_o = a1_o_q;
  assign addr1_or_dout_pin_oe = a1_oe_q;
  assign mode_is_i2c = in_i2c;
  assign mode_is_spi = in_spi;
  assign spi_selected = sel_s;
  assign slave_addr_lsbs = addr_q;
  assign data_line_sync = pin_s2_q[spcp_pkg::PIN_DATA];
  assign rx_byte = rx_q;
  assign rx_byte_valid = rx_vld_q;
  assign status_change_irq_n = ~irq_q;
  assign lock_lost_n = lock_q;
  assign clk_out_en = out_en_q;
  assign clk_out_fmt = fmt_q;
  assign core_rst_n = ~soft_rst;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  chk_mode_strap_latch: assert property (
    (mode_q == spcp_pkg::SPCP_WAIT && settle_q == spcp_pkg::SETTLE_CYCLES && !soft_rst)
    |=> (mode_q == ($past(i2c_sel_s) ? spcp_pkg::SPCP_I2C : spcp_pkg::SPCP_SPI)))
    else $error("mode does not follow the strap");
  chk_four_wire_input: assert property (
    (in_spi && !three_w_s) |=> !data_pin_oe)
    else $error("data pin driven in four-wire SPI");
  chk_i2c_open_drain: assert property (
    (in_i2c && !soft_rst) |=> (!data_pin_o && data_pin_oe == $past(core_drive_low)))
    else $error("I2C data pin not open drain");
  chk_dout_drive: assert property (
    (sel_s && !three_w_s && core_dout_en && !soft_rst)
    |=> (addr1_or_dout_pin_oe && addr1_or_dout_pin_o == $past(core_dout)))
    else $error("four-wire data out not driven");
  chk_strap_addr: assert property (
    (in_i2c && !soft_rst)
    |=> (!addr1_or_dout_pin_oe && slave_addr_lsbs == $past({addr1_s, addr0_s})))
    else $error("strapped address wrong");
  chk_irq_on_change: assert property (
    (stat_change && !soft_rst) |=> !status_change_irq_n
    ##1 (!status_change_irq_n || $past(status_clear) || $past(soft_rst)))
    else $error("status change not flagged");
  chk_reset_defaults: assert property (
    soft_rst |=> (mode_q == spcp_pkg::SPCP_WAIT && status_change_irq_n
    && clk_out_en == spcp_pkg::OUT_OFF)[*1])
    else $error("reset does not restore defaults");
  chk_outputs_off: assert property (
    (out_dis_s || soft_rst) |=> clk_out_en == spcp_pkg::OUT_OFF)
    else $error("clock outputs enabled while disabled");
  chk_fmt_follow: assert property (
    !soft_rst |=> clk_out_fmt == $past(out_fmt_cfg))
    else $error("format settings not applied");
  chk_lock_follow: assert property (
    !soft_rst |=> lock_lost_n == $past(pll_locked))
    else $error("lock indicator does not follow the PLL");
  chk_byte_pulse: assert property (
    rx_byte_valid |=> !rx_byte_valid)
    else $error("byte pulse longer than one cycle");
  cov_i2c_mode: cover property (in_i2c ##1 data_pin_oe);
  cov_spi_byte: cover property (in_spi && rx_byte_valid);
  cov_irq_clear: cover property (!status_change_irq_n ##1 status_change_irq_n);
  cov_outputs_run: cover property (clk_out_en == spcp_pkg::OUT_ALL);

endmodule

/* verif/spcp_host_model.sv */
// Behavioural serial host that clocks bytes into the serial port.
`timescale 1ns/1ps

module spcp_host_model (
  output logic serial_clk, // Host serial clock, still between frames.
  output logic host_dout, // Value the host puts on the data pin.
  output logic host_oe // High while the host drives the data pin.
);
  // ****************************************
  // Byte transfer
  // ****************************************

  // The clock rests low and the line is released until a frame starts.
  initial begin
    serial_clk = 1'b0;
    host_dout = 1'b0;
    host_oe = 1'b0;
  end

  // Sends one byte MSB first; data moves while the clock is low and is taken on the rise.
  // The odd start offset keeps the 15 ns clock clear of the system clock edges.
  task automatic send_byte(input logic [7:0] b);
    int i;
    #1.3;
    for (i = 7; i >= 0; i--) begin
      host_oe = 1'b1;
      host_dout = b[i];
      #7.5;
      serial_clk = 1'b1;
      #7.5;
      serial_clk = 1'b0;
    end
    host_oe = 1'b0;
    // A released line shows the inverse, so stale data never looks valid.
    host_dout = ~host_dout;
  endtask
endmodule

/* verif/tb.sv */
// Self-checking testbench for the serial port and control pin logic.
`timescale 1ns/1ps

module tb;
  // ****************************************
  // Signals
  // ****************************************

  // One table row: straps and core requests, then the expected pin drive.
  typedef struct packed {
    logic i2c, tw, a0, a1, cdl, cd, cde, oe, o, a1oe, a1o;
    logic [1:0] addr;
  } spcp_row_t;

  logic sys_clk, arst_n, i2c_sel_pin, spi_three_wire, data_pin_i, data_pin_o, data_pin_oe;
  logic addr1_or_dout_pin_i, addr1_or_dout_pin_o, addr1_or_dout_pin_oe, addr0_or_select_pin;
  logic device_reset_n, output_disable_pin, core_drive_low, core_dout, core_dout_en;
  logic status_clear, pll_locked, mode_is_i2c, mode_is_spi, spi_selected, data_line_sync;
  logic rx_byte_valid, status_change_irq_n, lock_lost_n, core_rst_n, a1_strap;
  logic serial_clk, host_dout, host_oe; // Driven by the host model.
  logic [spcp_pkg::STAT_W-1:0] status_vec; // Status levels fed to the design.
  logic [spcp_pkg::NUM_OUT*spcp_pkg::FMT_W-1:0] out_fmt_cfg, clk_out_fmt; // Format fields.
  logic [spcp_pkg::NUM_OUT-1:0] clk_out_en; // Observed clock enables.
  logic [spcp_pkg::BYTE_W-1:0] rx_byte; // Observed received byte.
  logic [1:0] slave_addr_lsbs; // Observed strap address bits.
  spcp_row_t rows [5]; // Ordinary cases.
  spcp_row_t r; // Row under test.
  int n_mismatch = 0; // Mismatches seen.
  int n_tests = 0; // Comparisons made.

  // Open drain in I2C: anyone driving low wins, else the pull-up; in SPI one driver at a time.
  assign data_pin_i = i2c_sel_pin ? ~((host_oe & ~host_dout) | (data_pin_oe & ~data_pin_o))
                                  : (host_oe ? host_dout : (data_pin_oe ? data_pin_o : host_dout));
  // The strap level shows unless the design drives the pin.
  assign addr1_or_dout_pin_i = addr1_or_dout_pin_oe ? addr1_or_dout_pin_o : a1_strap;

  // ****************************************
  // Instances and clock
  // ****************************************

  spcp_host_model host_u (.serial_clk(serial_clk), .host_dout(host_dout), .host_oe(host_oe));

  spcp_top DUT (
    .sys_clk(sys_clk), .arst_n(arst_n), .serial_clk(serial_clk), .i2c_sel_pin(i2c_sel_pin),
    .spi_three_wire(spi_three_wire), .data_pin_i(data_pin_i), .data_pin_o(data_pin_o),
    .data_pin_oe(data_pin_oe), .addr1_or_dout_pin_i(addr1_or_dout_pin_i),
    .addr1_or_dout_pin_o(addr1_or_dout_pin_o), .addr1_or_dout_pin_oe(addr1_or_dout_pin_oe),
    .addr0_or_select_pin(addr0_or_select_pin), .device_reset_n(device_reset_n),
    .output_disable_pin(output_disable_pin), .core_drive_low(core_drive_low),
    .core_dout(core_dout), .core_dout_en(core_dout_en), .status_vec(status_vec),
    .status_clear(status_clear), .pll_locked(pll_locked), .out_fmt_cfg(out_fmt_cfg),
    .mode_is_i2c(mode_is_i2c), .mode_is_spi(mode_is_spi), .spi_selected(spi_selected),
    .slave_addr_lsbs(slave_addr_lsbs), .data_line_sync(data_line_sync), .rx_byte(rx_byte),
    .rx_byte_valid(rx_byte_valid), .status_change_irq_n(status_change_irq_n),
    .lock_lost_n(lock_lost_n), .clk_out_en(clk_out_en), .clk_out_fmt(clk_out_fmt),
    .core_rst_n(core_rst_n));

  // The 200 MHz system clock.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Tasks
  // ****************************************

  // Compares with case equality so an unknown never passes.
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Resets with the given straps and waits, bounded, for the mode to latch.
  task automatic do_reset(input logic i2c, input logic tw);
    int k;
    arst_n <= 1'b0;
    i2c_sel_pin <= i2c;
    spi_three_wire <= tw;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(clk_out_en, spcp_pkg::OUT_OFF);
    chk(status_change_irq_n, 1'b1);
    chk(core_rst_n, 1'b0);
    @(posedge sys_clk);
    arst_n <= 1'b1;
    for (k = 0; k < 30 && mode_is_i2c !== 1'b1 && mode_is_spi !== 1'b1; k++) begin
      @(negedge sys_clk);
    end
    if (k == 30) begin
      chk(64'h0, 64'h1);
      end_of_test();
    end
  endtask

  // Waits, bounded, for the one-cycle byte pulse and checks the byte.
  task automatic wait_byte(input logic [7:0] exp);
    int k;
    for (k = 0; k < 40 && rx_byte_valid !== 1'b1; k++) begin
      @(negedge sys_clk);
    end
    chk(rx_byte, exp);
    if (k == 40) begin
      chk(64'h0, 64'h1);
      end_of_test();
    end
  endtask

  // ****************************************
  // Sequence
  // ****************************************

  initial begin
    {i2c_sel_pin, arst_n, spi_three_wire, core_drive_low, core_dout, core_dout_en} = 6'h20;
    {device_reset_n, addr0_or_select_pin, a1_strap, output_disable_pin} = 4'hC;
    {status_clear, pll_locked, status_vec, out_fmt_cfg} = '0;
    rows[0] = 13'h1521; // I2C, pull low, straps 01.
    rows[1] = 13'h1242; // I2C, no pull, SPI request ignored, straps 10.
    rows[2] = 13'h08F0; // Three-wire SPI, selected, drives data pin.
    rows[3] = 13'h00CC; // Four-wire SPI, selected, drives data out pin.
    rows[4] = 13'h04C0; // Four-wire SPI, not selected, drives nothing.
    for (int n = 0; n < 5; n++) begin
      r = rows[n];
      @(posedge sys_clk);
      addr0_or_select_pin <= r.a0;
      a1_strap <= r.a1;
      core_drive_low <= r.cdl;
      core_dout <= r.cd;
      core_dout_en <= r.cde;
      do_reset(r.i2c, r.tw);
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(mode_is_i2c, r.i2c);
      chk(mode_is_spi, !r.i2c);
      chk(data_pin_oe, r.oe);
      if (r.oe) chk(data_line_sync, r.o);
      if (r.oe || r.i2c) chk(data_pin_o, r.o);
      chk(addr1_or_dout_pin_oe, r.a1oe);
      if (r.a1oe) chk(addr1_or_dout_pin_o, r.a1o);
      chk(slave_addr_lsbs, r.addr);
      chk(spi_selected, !r.i2c && !r.a0);
    end
    // Four-wire SPI: select, then clock a byte in.
    @(posedge sys_clk);
    addr0_or_select_pin <= 1'b0;
    core_dout_en <= 1'b0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    host_u.send_byte(8'hA5);
    wait_byte(8'hA5);
    // I2C: same clock pin, open-drain data line.
    @(posedge sys_clk);
    core_drive_low <= 1'b0;
    do_reset(1'b1, 1'b0);
    repeat (2) @(negedge sys_clk);
    chk(clk_out_en, spcp_pkg::OUT_ALL);
    chk(data_line_sync, 1'b1);
    host_u.send_byte(8'h3C);
    wait_byte(8'h3C);
    // A status change raises the interrupt until cleared.
    @(posedge sys_clk);
    status_vec <= 4'h9;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(status_change_irq_n, 1'b0);
    @(posedge sys_clk);
    status_clear <= 1'b1;
    @(posedge sys_clk);
    status_clear <= 1'b0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(status_change_irq_n, 1'b1);
    // Disable, format and lock, then back.
    @(posedge sys_clk);
    out_fmt_cfg <= 36'hFAC688123;
    pll_locked <= 1'b1;
    output_disable_pin <= 1'b1;
    repeat (5) @(negedge sys_clk);
    chk(clk_out_fmt, 36'hFAC688123);
    chk(lock_lost_n, 1'b1);
    chk(clk_out_en, spcp_pkg::OUT_OFF);
    @(posedge sys_clk);
    pll_locked <= 1'b0;
    output_disable_pin <= 1'b0;
    repeat (5) @(negedge sys_clk);
    chk(lock_lost_n, 1'b0);
    chk(clk_out_en, spcp_pkg::OUT_ALL);
    // Device reset pin with a status change on the same edge.
    @(posedge sys_clk);
    device_reset_n <= 1'b0;
    status_vec <= 4'h0;
    repeat (5) @(negedge sys_clk);
    chk(clk_out_en, spcp_pkg::OUT_OFF);
    chk({core_rst_n, status_change_irq_n, mode_is_i2c}, 3'h2);
    chk(clk_out_fmt, spcp_pkg::FMT_RST);
    end_of_test();
  end
endmodule
